/* File: logic/rmdr_cfg.svh */
`ifndef RMDR_CFG_SVH
`define RMDR_CFG_SVH

// ============================================================
// Register offsets on the internal host register port.
`define RMDR_ADDR_W 8
`define RMDR_DATA_W 8
`define RMDR_ADDR_REF4_DET 8'h13
`define RMDR_ADDR_SYNC0_DET 8'h14
`define RMDR_ADDR_OOR0 8'h16
`define RMDR_ADDR_OOR1 8'h17
`define RMDR_ADDR_OOR2 8'h18
`define RMDR_ADDR_MASK0 8'h1a
`define RMDR_ADDR_MASK1 8'h1b

// ============================================================
// Field layout and reset values.
`define RMDR_NUM_REFS 5
`define RMDR_CODE4_W 4
`define RMDR_SYNC_CODE_W 3
`define RMDR_SEL_W 3
`define RMDR_INHIBIT_W 2
`define RMDR_SEL_HI_LSB 4
`define RMDR_SYNC_FAIL_BIT 3
`define RMDR_SINGLE_CYCLE_BIT 0
`define RMDR_COARSE_FREQ_BIT 1
`define RMDR_OOR_RST 8'h33
`define RMDR_MASK_RST 8'hff
`define RMDR_SEL_RST 3'h3
`define RMDR_INHIBIT_RST 2'h3
`define RMDR_CODE4_PENDING 4'hf
`define RMDR_SYNC_PENDING 3'h6

`endif

/* File: logic/rmdr_pkg.sv */
`default_nettype none
`include "rmdr_cfg.svh"

package rmdr_pkg;

  // Host register port request, one access per cycle.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`RMDR_ADDR_W-1:0] addr;
    logic [`RMDR_DATA_W-1:0] wdata;
  } rmdr_bus_req_type;

  // Results arriving from the reference and sync monitors.
  typedef struct packed {
    logic [`RMDR_CODE4_W-1:0] input4_freq_code;
    logic [`RMDR_SYNC_CODE_W-1:0] frame_sync0_freq_code;
    logic frame_sync0_failed;
    logic [`RMDR_NUM_REFS-1:0] single_cycle_monitor_fail;
    logic [`RMDR_NUM_REFS-1:0] coarse_frequency_monitor_fail;
  } rmdr_mon_type;

  typedef logic [`RMDR_NUM_REFS-1:0][`RMDR_SEL_W-1:0] rmdr_limits_type;
  typedef logic [`RMDR_NUM_REFS-1:0][`RMDR_INHIBIT_W-1:0] rmdr_inhibits_type;

endpackage

`default_nettype wire

/* File: logic/rmdr_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rmdr_cfg.svh"

module rmdr_regs (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Host register port.
  input wire rmdr_pkg::rmdr_bus_req_type bus_req,
  output logic [`RMDR_DATA_W-1:0] rd_data,
  output logic rd_valid,
  // Monitor results.
  input wire rmdr_pkg::rmdr_mon_type mon,
  // Monitor controls and guard soak timer inputs.
  output var rmdr_pkg::rmdr_limits_type range_limit,
  output logic [`RMDR_NUM_REFS-1:0] soak_single_cycle_fail,
  output logic [`RMDR_NUM_REFS-1:0] soak_coarse_freq_fail
);
  import rmdr_pkg::*;

  // ============================================================
  // Helpers
  // Packs two selectors into one byte with reserved bits at zero.
  function automatic logic [`RMDR_DATA_W-1:0] pack_pair(
    input logic [`RMDR_SEL_W-1:0] lo, input logic [`RMDR_SEL_W-1:0] hi);
    logic [`RMDR_DATA_W-1:0] v;
    v = '0;
    v[`RMDR_SEL_W-1:0] = lo;
    v[`RMDR_SEL_HI_LSB +: `RMDR_SEL_W] = hi;
    return v;
  endfunction

  // ============================================================
  // State
  rmdr_inhibits_type soak_inhibit, next_soak_inhibit;
  rmdr_limits_type next_range_limit;
  logic [`RMDR_CODE4_W-1:0] input4_freq_code, next_input4_freq_code;
  logic [`RMDR_SYNC_CODE_W-1:0] frame_sync0_freq_code, next_frame_sync0_freq_code;
  logic frame_sync0_failed, next_frame_sync0_failed;
  logic [`RMDR_DATA_W-1:0] next_rd_data;
  logic next_rd_valid;
  logic [`RMDR_NUM_REFS-1:0] next_soak_single_cycle_fail, next_soak_coarse_freq_fail;

  // ============================================================
  // Status capture: monitor results are copied every cycle.
  always_comb begin
    next_input4_freq_code = mon.input4_freq_code;
    next_frame_sync0_freq_code = mon.frame_sync0_freq_code;
    next_frame_sync0_failed = mon.frame_sync0_failed;
  end

  // Reset loads the pending codes into the status registers; every later edge takes the monitor results.
  always_ff @(posedge clk) begin
    if (srst) begin
      input4_freq_code <= `RMDR_CODE4_PENDING;
      frame_sync0_freq_code <= `RMDR_SYNC_PENDING;
      frame_sync0_failed <= 1'b0;
    end else begin
      input4_freq_code <= next_input4_freq_code;
      frame_sync0_freq_code <= next_frame_sync0_freq_code;
      frame_sync0_failed <= next_frame_sync0_failed;
    end
  end

  // ============================================================
  // Control writes: selectors and soak inhibit masks.
  always_comb begin
    next_range_limit = range_limit;
    next_soak_inhibit = soak_inhibit;
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        `RMDR_ADDR_OOR0: begin
          next_range_limit[0] = bus_req.wdata[`RMDR_SEL_W-1:0];
          next_range_limit[1] = bus_req.wdata[`RMDR_SEL_HI_LSB +: `RMDR_SEL_W];
        end
        `RMDR_ADDR_OOR1: begin
          next_range_limit[2] = bus_req.wdata[`RMDR_SEL_W-1:0];
          next_range_limit[3] = bus_req.wdata[`RMDR_SEL_HI_LSB +: `RMDR_SEL_W];
        end
        `RMDR_ADDR_OOR2: begin
          next_range_limit[4] = bus_req.wdata[`RMDR_SEL_W-1:0];
        end
        `RMDR_ADDR_MASK0: begin
          for (int i = 0; i < `RMDR_NUM_REFS - 1; i++) begin
            next_soak_inhibit[i] = bus_req.wdata[i*`RMDR_INHIBIT_W +: `RMDR_INHIBIT_W];
          end
        end
        `RMDR_ADDR_MASK1: begin
          next_soak_inhibit[4] = bus_req.wdata[`RMDR_INHIBIT_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Selectors start at the 64-83 ppm limit and every inhibit bit starts set.
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < `RMDR_NUM_REFS; i++) begin
        range_limit[i] <= `RMDR_SEL_RST;
        soak_inhibit[i] <= `RMDR_INHIBIT_RST;
      end
    end else begin
      range_limit <= next_range_limit;
      soak_inhibit <= next_soak_inhibit;
    end
  end

  // ============================================================
  // Register reads: data is returned one cycle after the strobe.
  always_comb begin
    next_rd_valid = bus_req.rd;
    next_rd_data = '0;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `RMDR_ADDR_REF4_DET: next_rd_data[`RMDR_CODE4_W-1:0] = input4_freq_code;
        `RMDR_ADDR_SYNC0_DET: begin
          next_rd_data[`RMDR_SYNC_CODE_W-1:0] = frame_sync0_freq_code;
          next_rd_data[`RMDR_SYNC_FAIL_BIT] = frame_sync0_failed;
        end
        `RMDR_ADDR_OOR0: next_rd_data = pack_pair(range_limit[0], range_limit[1]);
        `RMDR_ADDR_OOR1: next_rd_data = pack_pair(range_limit[2], range_limit[3]);
        `RMDR_ADDR_OOR2: next_rd_data[`RMDR_SEL_W-1:0] = range_limit[4];
        `RMDR_ADDR_MASK0: begin
          for (int i = 0; i < `RMDR_NUM_REFS - 1; i++) begin
            next_rd_data[i*`RMDR_INHIBIT_W +: `RMDR_INHIBIT_W] = soak_inhibit[i];
          end
        end
        `RMDR_ADDR_MASK1: next_rd_data[`RMDR_INHIBIT_W-1:0] = soak_inhibit[4];
        default: next_rd_data = '0;
      endcase
    end
  end

  // Read data is registered, so the port answers one cycle after the strobe.
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  // ============================================================
  // Guard soak timer gating: a set inhibit bit blocks that failure.
  always_comb begin
    for (int i = 0; i < `RMDR_NUM_REFS; i++) begin
      next_soak_single_cycle_fail[i] = mon.single_cycle_monitor_fail[i] &
                                       ~soak_inhibit[i][`RMDR_SINGLE_CYCLE_BIT];
      next_soak_coarse_freq_fail[i] = mon.coarse_frequency_monitor_fail[i] &
                                      ~soak_inhibit[i][`RMDR_COARSE_FREQ_BIT];
    end
  end

  // Gated failures are registered so the timer only ever sees flop outputs.
  always_ff @(posedge clk) begin
    if (srst) begin
      soak_single_cycle_fail <= '0;
      soak_coarse_freq_fail <= '0;
    end else begin
      soak_single_cycle_fail <= next_soak_single_cycle_fail;
      soak_coarse_freq_fail <= next_soak_coarse_freq_fail;
    end
  end

  // ============================================================
  // Checks
  // Checks look at registered outputs one edge after the cause, except the reset checks, which look on the edge where srst falls.
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_code4_read: assert property (bus_req.rd && bus_req.addr == `RMDR_ADDR_REF4_DET |=>
    rd_valid && rd_data == {4'h0, $past(input4_freq_code)}) else $error("ref4 code read wrong");
  a_code4_track: assert property (##1 input4_freq_code == $past(mon.input4_freq_code))
    else $error("ref4 code not captured");
  a_sync_code_read: assert property (bus_req.rd && bus_req.addr == `RMDR_ADDR_SYNC0_DET |=>
    rd_data[2:0] == $past(frame_sync0_freq_code) && rd_data[7:4] == 4'h0)
    else $error("sync0 code read wrong");
  a_sync_fail_flag: assert property (mon.frame_sync0_failed ##1 bus_req.rd &&
    bus_req.addr == `RMDR_ADDR_SYNC0_DET |=> rd_data[3]) else $error("frame_sync0_failed not shown");
  a_limit_write: assert property (bus_req.wr && bus_req.addr == `RMDR_ADDR_OOR1 |=>
    range_limit[3] == $past(bus_req.wdata[6:4]) && range_limit[2] == $past(bus_req.wdata[2:0]))
    else $error("limit write lost");
  a_limit_reset: assert property ($fell(srst) |-> range_limit == {5{3'h3}})
    else $error("limit reset wrong");
  a_limit_readback: assert property (bus_req.rd && bus_req.addr == `RMDR_ADDR_OOR0 |=>
    rd_data[3] == 1'b0 && rd_data[7] == 1'b0 && rd_data[6:4] == $past(range_limit[1]))
    else $error("limit readback wrong");
  a_mask_write: assert property (bus_req.wr && bus_req.addr == `RMDR_ADDR_MASK0 |=>
    soak_inhibit[3] == $past(bus_req.wdata[7:6])) else $error("mask write lost");
  a_mask_gate: assert property (soak_inhibit[2][1] |=> !soak_coarse_freq_fail[2])
    else $error("frequency failure passed while inhibited");
  a_cycle_pass: assert property (!soak_inhibit[0][0] && mon.single_cycle_monitor_fail[0]
    |=> soak_single_cycle_fail[0]) else $error("single cycle failure dropped");
  a_limit4_write: assert property (bus_req.wr && bus_req.addr == `RMDR_ADDR_OOR2 |=>
    range_limit[4] == $past(bus_req.wdata[2:0])) else $error("ref4 limit write lost");
  a_inhibit_reset: assert property ($fell(srst) |-> soak_inhibit == '1)
    else $error("inhibit reset wrong");
  a_idle_quiet: assert property (!bus_req.rd |=> !rd_valid && rd_data == '0)
    else $error("read port not quiet");
  a_reserved_zero: assert property (bus_req.rd && bus_req.addr == `RMDR_ADDR_MASK1 |=>
    rd_data[7:2] == 6'h00) else $error("reserved bits not zero");

  c_sync_fail_read: cover property (bus_req.rd && bus_req.addr == `RMDR_ADDR_SYNC0_DET ##1 rd_data[3]);
  c_limit_change: cover property (bus_req.wr && bus_req.addr == `RMDR_ADDR_OOR2 ##1 range_limit[4] != 3'h3);
  c_unmask_pass: cover property (soak_single_cycle_fail[4] ##1 soak_coarse_freq_fail[4]);
  c_freq_fail_pass: cover property (!soak_inhibit[1][1] ##1 soak_coarse_freq_fail[1]);

endmodule

`default_nettype wire

/* File: verification/rmdr_ref_source.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========
// Source model: shows a requested monitor state after a falling edge.
module rmdr_ref_source (
  // Clock and pacing.
  input wire logic clk,
  input wire logic slow,
  // Requested and presented monitor state.
  input wire rmdr_pkg::rmdr_mon_type want,
  output var rmdr_pkg::rmdr_mon_type mon
);
  import rmdr_pkg::*;
  logic held = 1'b0;
  // A slow source keeps the old state for one extra cycle.
  always @(negedge clk) begin
    held <= slow && !held && want != mon;
    if (!(slow && !held && want != mon)) begin
      mon <= want;
    end
  end
endmodule
`default_nettype wire

/* File: verification/test_rmdr_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module test_rmdr_regs;
  import rmdr_pkg::*;
  // ==========
  // Clock, stimulus and design.
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic slow = 1'b0;
  rmdr_bus_req_type bus_req = '0;
  rmdr_mon_type want = '0;
  rmdr_mon_type mon;
  logic [7:0] rd_data;
  logic rd_valid;
  rmdr_limits_type range_limit;
  logic [4:0] soak_single_cycle_fail;
  logic [4:0] soak_coarse_freq_fail;
  int mismatches = 0;
  int comparisons = 0;
  int mreg [256];
  int raddr [8] = '{8'h13, 8'h14, 8'h16, 8'h17, 8'h18, 8'h1a, 8'h1b, 8'h20};
  always #2.5 clk = ~clk;
  rmdr_ref_source src (.clk(clk), .slow(slow), .want(want), .mon(mon));
  rmdr_regs dut (.clk(clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .mon(mon), .range_limit(range_limit),
    .soak_single_cycle_fail(soak_single_cycle_fail),
    .soak_coarse_freq_fail(soak_coarse_freq_fail));
  // ==========
  // Reference model: stored bytes, writable bits and expected reads.
  function automatic int wmask(int a);
    case (a)
      8'h16, 8'h17: return 8'h77;
      8'h18: return 8'h07;
      8'h1a: return 8'hff;
      8'h1b: return 8'h03;
      default: return 0;
    endcase
  endfunction
  function automatic int exp_rd(int a);
    if (a == 8'h13) return want[17:14];
    if (a == 8'h14) return {want[10], want[13:11]};
    return mreg[a] & wmask(a);
  endfunction
  // ==========
  // Bus cycles and comparisons.
  task automatic note(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(int a, int d);
    @(negedge clk);
    bus_req <= {1'b1, 1'b0, 8'(a), 8'(d)};
    mreg[a] = d;
    @(negedge clk);
    bus_req <= '0;
  endtask
  task automatic chk_read(int a);
    @(negedge clk);
    bus_req <= {1'b0, 1'b1, 8'(a), 8'h00};
    @(negedge clk);
    bus_req <= '0;
    note({7'h00, rd_valid, rd_data}, 16'h0100 | 16'(exp_rd(a)));
  endtask
  task automatic chk_lims();
    logic [14:0] e;
    e = {3'(mreg[8'h18]), 3'(mreg[8'h17] >> 4), 3'(mreg[8'h17]), 3'(mreg[8'h16] >> 4),
      3'(mreg[8'h16])};
    note({1'b0, range_limit}, {1'b0, e});
  endtask
  task automatic chk_soak();
    logic [9:0] inh;
    inh = {2'(mreg[8'h1b]), 8'(mreg[8'h1a])};
    for (int i = 0; i < 5; i++) begin
      note({15'h0000, soak_single_cycle_fail[i]}, {15'h0000, want[5 + i] & ~inh[2 * i]});
      note({15'h0000, soak_coarse_freq_fail[i]}, {15'h0000, want[i] & ~inh[2 * i + 1]});
    end
  endtask
  task automatic do_reset();
    @(negedge clk);
    srst <= 1'b1;
    repeat (8) @(negedge clk);
    srst <= 1'b0;
    foreach (mreg[a]) mreg[a] = (a >= 8'h16 && a <= 8'h18) ? 8'h33 : 8'hff;
    foreach (raddr[j]) chk_read(raddr[j]);
    chk_lims();
    chk_soak();
    $display("Reset test done");
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========
  // Main sequence.
  initial begin
    void'($urandom(32'h576f750e));
    want <= {4'hf, 3'h6, 11'h000};
    do_reset();
    // Every selector code in every slot, reserved bits randomly set.
    for (int k = 0; k < 8; k++) begin
      for (int a = 8'h16; a <= 8'h18; a++) wr(a, ($urandom & 8'h88) | k | ((7 - k) << 4));
      chk_lims();
      for (int a = 8'h16; a <= 8'h18; a++) chk_read(a);
    end
    $display("Selector test done");
    // Every status code, random failures and inhibits, prompt and slow source.
    for (int i = 0; i < 16; i++) begin
      slow <= i[0];
      wr(8'h1a, $urandom);
      wr(8'h1b, $urandom);
      want <= {4'(i), 3'(i), i[1], 10'($urandom)};
      repeat (3) @(negedge clk);
      chk_soak();
      chk_read(8'h13);
      chk_read(8'h14);
      chk_read(8'h1b);
    end
    $display("Monitor test done");
    // Writes to a status byte and an unmapped offset change nothing.
    wr(8'h13, 8'h5a);
    wr(8'h20, 8'hff);
    chk_read(8'h13);
    chk_read(8'h20);
    $display("Read-only test done");
    do_reset();
    wrap_up();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
